// ### hw/tlic_pkg.sv
// Constants, register map and types of the two-level interrupt controller
package tlic_pkg;

    // ********************************************************
    // Register offsets and reset values
    // ********************************************************
    localparam logic [7:0] ADDR_ENABLE = 8'hA8;
    localparam logic [7:0] ADDR_SECONDARY = 8'hA9;
    localparam logic [7:0] ADDR_PRIORITY = 8'hB8;
    localparam logic [7:0] ADDR_WDC = 8'hC0;
    localparam logic [7:0] ADDR_STAT = 8'hC1;
    localparam logic [7:0] RST_ENABLE = 8'h00;
    localparam logic [7:0] RST_SECONDARY = 8'hA0;
    localparam logic [7:0] RST_PRIORITY = 8'h00;
    localparam logic [7:0] RST_WDC = 8'h00;
    // Bit-addressable registers occupy these upper five address bits
    localparam logic [4:0] BIT_BASE_ENABLE = 5'h15;
    localparam logic [4:0] BIT_BASE_PRIORITY = 5'h17;

    // ********************************************************
    // Field positions
    // ********************************************************
    localparam int EN_GLOBAL = 7;
    localparam int EN_ADC = 6;
    localparam int EN_T2 = 5;
    localparam int EN_UART = 4;
    localparam int EN_T1 = 3;
    localparam int EN_EXT1 = 2;
    localparam int EN_T0 = 1;
    localparam int EN_EXT0 = 0;
    localparam int PRI_RESERVED = 7;
    localparam int SEC_WK_PRIO = 6;
    localparam int SEC_PSM_PRIO = 5;
    localparam int SEC_SPI_PRIO = 4;
    localparam int SEC_WK_EN = 2;
    localparam int SEC_PSM_EN = 1;
    localparam int SEC_SPI_EN = 0;
    localparam int WDC_SEL = 0;
    localparam int WDC_TMO_LSB = 4;
    localparam int WDC_TMO_MSB = 7;

    // ********************************************************
    // Sources in polling order, index 0 polled first
    // ********************************************************
    localparam int NUM_SRC = 11;
    localparam logic [3:0] SRC_PSM = 4'h0;
    localparam logic [3:0] SRC_WD = 4'h1;
    localparam logic [3:0] SRC_EXT0 = 4'h2;
    localparam logic [3:0] SRC_ADC = 4'h3;
    localparam logic [3:0] SRC_T0 = 4'h4;
    localparam logic [3:0] SRC_EXT1 = 4'h5;
    localparam logic [3:0] SRC_T1 = 4'h6;
    localparam logic [3:0] SRC_SPI = 4'h7;
    localparam logic [3:0] SRC_UART = 4'h8;
    localparam logic [3:0] SRC_T2 = 4'h9;
    localparam logic [3:0] SRC_WK = 4'hA;

    // Service state, one-hot
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_LO = 4'b0010,
        ST_HI = 4'b0100,
        ST_HI_LO = 4'b1000
    } tlic_state_e;

    // Code address that each source jumps to
    function automatic logic [15:0] vector_of(input logic [3:0] idx);
        logic [15:0] v;
        v = 16'h0000;
        case (idx)
            SRC_EXT0: v = 16'h0003;
            SRC_T0: v = 16'h000B;
            SRC_EXT1: v = 16'h0013;
            SRC_T1: v = 16'h001B;
            SRC_UART: v = 16'h0023;
            SRC_T2: v = 16'h002B;
            SRC_ADC: v = 16'h0033;
            SRC_SPI: v = 16'h003B;
            SRC_PSM: v = 16'h0043;
            SRC_WK: v = 16'h0053;
            SRC_WD: v = 16'h005B;
            default: v = 16'h0000;
        endcase
        return v;
    endfunction

endpackage

// ### hw/tlic_arb.sv
// Fixed-order two-level request arbiter
`timescale 1ns/1ns
module tlic_arb (
    input wire logic [10:0] cand,
    input wire logic [10:0] hi,
    output logic gnt_valid,
    output logic [3:0] gnt_idx,
    output logic gnt_hi
);

    // ********************************************************
    // Level pick, then lowest index inside the level
    // ********************************************************
    logic [10:0] hi_cand;
    logic [10:0] pool;

    // High level wins outright when any is present
    always_comb
    begin
        hi_cand = cand & hi;
        pool = (|hi_cand) ? hi_cand : cand;
        gnt_valid = |cand;
        gnt_hi = |hi_cand;
        gnt_idx = 4'h0;
        // Scan downward so the lowest index is left last
        for (int i = 10; i >= 0; i--)
        begin
            if (pool[i])
            begin
                gnt_idx = 4'(i);
            end
        end
    end

endmodule

// ### hw/tlic_regs.sv
// Register file of the interrupt controller with byte and bit writes
`timescale 1ns/1ns
module tlic_regs (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic bit_wr,
    input wire logic [7:0] bit_addr,
    input wire logic bit_wdata,
    input wire logic [7:0] status,
    output logic [7:0] irq_enable_reg_q,
    output logic [7:0] irq_priority_reg_q,
    output logic [7:0] secondary_irq_ctrl_q,
    output logic [7:0] wdc_q,
    output logic [7:0] rdata_q
);

    // ********************************************************
    // Storage and read mux
    // ********************************************************
    logic [7:0] irq_enable_reg_d;
    logic [7:0] irq_priority_reg_d;
    logic [7:0] secondary_irq_ctrl_d;
    logic [7:0] wdc_d;
    logic [7:0] rdata_d;

    // Byte write first, then single-bit write on top of it
    always_comb
    begin
        irq_enable_reg_d = irq_enable_reg_q;
        irq_priority_reg_d = irq_priority_reg_q;
        secondary_irq_ctrl_d = secondary_irq_ctrl_q;
        wdc_d = wdc_q;
        rdata_d = 8'h00;
        if (wr && addr == tlic_pkg::ADDR_ENABLE)
            irq_enable_reg_d = wdata;
        if (wr && addr == tlic_pkg::ADDR_PRIORITY)
            irq_priority_reg_d = wdata;
        // Reserved bit 3 is stored as written and steers nothing
        if (wr && addr == tlic_pkg::ADDR_SECONDARY)
            secondary_irq_ctrl_d = wdata;
        if (wr && addr == tlic_pkg::ADDR_WDC)
            wdc_d = wdata;
        if (bit_wr && bit_addr[7:3] == tlic_pkg::BIT_BASE_ENABLE)
            irq_enable_reg_d[bit_addr[2:0]] = bit_wdata;
        if (bit_wr && bit_addr[7:3] == tlic_pkg::BIT_BASE_PRIORITY)
            irq_priority_reg_d[bit_addr[2:0]] = bit_wdata;
        // Unmapped offsets read as zero
        if (rd)
        begin
            case (addr)
                tlic_pkg::ADDR_ENABLE: rdata_d = irq_enable_reg_q;
                tlic_pkg::ADDR_PRIORITY:
                    rdata_d = irq_priority_reg_q & ~(8'h01 << tlic_pkg::PRI_RESERVED);
                tlic_pkg::ADDR_SECONDARY: rdata_d = secondary_irq_ctrl_q;
                tlic_pkg::ADDR_WDC: rdata_d = wdc_q;
                tlic_pkg::ADDR_STAT: rdata_d = status;
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_enable_reg_q <= tlic_pkg::RST_ENABLE;
            irq_priority_reg_q <= tlic_pkg::RST_PRIORITY;
            secondary_irq_ctrl_q <= tlic_pkg::RST_SECONDARY;
            wdc_q <= tlic_pkg::RST_WDC;
            rdata_q <= 8'h00;
        end
        else
        begin
            irq_enable_reg_q <= irq_enable_reg_d;
            irq_priority_reg_q <= irq_priority_reg_d;
            secondary_irq_ctrl_q <= secondary_irq_ctrl_d;
            wdc_q <= wdc_d;
            rdata_q <= rdata_d;
        end
    end

endmodule

// ### hw/tlic_top.sv
// Top of the two-level interrupt controller: gating, service state, vectors
//
// Operation
// - Enable bit 7 gates all maskable sources
// - Enable bits 6..0 gate seven core sources
// - Priority bits 6..0 pick level; bit 7 reserved
// - Secondary bits 6..4 pick three source levels
// - Secondary bits 2..0 enable three sources
// - High request preempts low service routine
// - Simultaneous mixed levels: high served first
// - Same level never preempts running routine
// - Same level resolved by fixed polling order
// - Acceptance pushes PC, loads source vector
// - Each source has its fixed vector address
// - Watchdog select makes timeout an interrupt
// - Watchdog interrupt always at high level
// - Global enable never masks watchdog interrupt
// - Watchdog interrupts only with nonzero timeout
// - Enable register resets zero, bit-addressable
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ns
module tlic_top (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic bit_wr,
    input wire logic [7:0] bit_addr,
    input wire logic bit_wdata,
    input wire logic supply_monitor_irq_flag,
    input wire logic ext0_irq_flag,
    input wire logic primary_adc_done,
    input wire logic aux_adc_done,
    input wire logic timer0_overflow_flag,
    input wire logic ext1_irq_flag,
    input wire logic timer1_overflow_flag,
    input wire logic spi_irq_flag,
    input wire logic uart_rx_flag,
    input wire logic uart_tx_flag,
    input wire logic timer2_overflow_flag,
    input wire logic timer2_external_flag,
    input wire logic wakeup_counter_irq_flag,
    input wire logic wd_timeout,
    input wire logic insn_boundary,
    input wire logic reti_done,
    output logic irq_take,
    output logic [15:0] irq_vector,
    output logic [3:0] irq_src,
    output logic wd_reset_req
);

    // ********************************************************
    // Reset release
    // ********************************************************
    logic [1:0] sync_q;
    logic [1:0] sync_d;
    logic rst_s_n;

    // Two stages so release never lands mid-setup
    always_comb
    begin
        sync_d = {sync_q[0], 1'b1};
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            sync_q <= 2'b00;
        else
            sync_q <= sync_d;
    end

    assign rst_s_n = sync_q[1];

    // ********************************************************
    // Registers
    // ********************************************************
    logic [7:0] irq_enable_reg;
    logic [7:0] irq_priority_reg;
    logic [7:0] secondary_irq_ctrl;
    logic [7:0] wdc;
    logic [7:0] status;
    logic wd_flag_q;
    logic wd_flag_d;
    tlic_pkg::tlic_state_e state_q;
    tlic_pkg::tlic_state_e state_d;
    logic hi_active;
    logic lo_active;

    tlic_regs u_regs (
        .clk(core_clk),
        .rst_n(rst_s_n),
        .addr(reg_addr),
        .wdata(reg_wdata),
        .wr(reg_wr),
        .rd(reg_rd),
        .bit_wr(bit_wr),
        .bit_addr(bit_addr),
        .bit_wdata(bit_wdata),
        .status(status),
        .irq_enable_reg_q(irq_enable_reg),
        .irq_priority_reg_q(irq_priority_reg),
        .secondary_irq_ctrl_q(secondary_irq_ctrl),
        .wdc_q(wdc),
        .rdata_q(reg_rdata)
    );

    // Live state shown to software
    always_comb
    begin
        hi_active = state_q == tlic_pkg::ST_HI || state_q == tlic_pkg::ST_HI_LO;
        lo_active = state_q == tlic_pkg::ST_LO || state_q == tlic_pkg::ST_HI_LO;
        status = {1'b0, wd_flag_q, hi_active, lo_active, irq_src};
    end

    // ********************************************************
    // Request gating
    // ********************************************************
    logic [10:0] req;
    logic [10:0] en;
    logic [10:0] hi;
    logic [10:0] elig;
    logic [10:0] cand;
    logic [10:0] wd_only;

    // Shared flags of one peripheral merge into one request
    always_comb
    begin
        req = '0;
        req[tlic_pkg::SRC_PSM] = supply_monitor_irq_flag;
        req[tlic_pkg::SRC_WD] = wd_flag_q;
        req[tlic_pkg::SRC_EXT0] = ext0_irq_flag;
        req[tlic_pkg::SRC_ADC] = primary_adc_done | aux_adc_done;
        req[tlic_pkg::SRC_T0] = timer0_overflow_flag;
        req[tlic_pkg::SRC_EXT1] = ext1_irq_flag;
        req[tlic_pkg::SRC_T1] = timer1_overflow_flag;
        req[tlic_pkg::SRC_SPI] = spi_irq_flag;
        req[tlic_pkg::SRC_UART] = uart_rx_flag | uart_tx_flag;
        req[tlic_pkg::SRC_T2] = timer2_overflow_flag | timer2_external_flag;
        req[tlic_pkg::SRC_WK] = wakeup_counter_irq_flag;
    end

    always_comb
    begin
        en = '0;
        en[tlic_pkg::SRC_PSM] = secondary_irq_ctrl[tlic_pkg::SEC_PSM_EN];
        en[tlic_pkg::SRC_WD] = 1'b1;
        en[tlic_pkg::SRC_EXT0] = irq_enable_reg[tlic_pkg::EN_EXT0];
        en[tlic_pkg::SRC_ADC] = irq_enable_reg[tlic_pkg::EN_ADC];
        en[tlic_pkg::SRC_T0] = irq_enable_reg[tlic_pkg::EN_T0];
        en[tlic_pkg::SRC_EXT1] = irq_enable_reg[tlic_pkg::EN_EXT1];
        en[tlic_pkg::SRC_T1] = irq_enable_reg[tlic_pkg::EN_T1];
        en[tlic_pkg::SRC_SPI] = secondary_irq_ctrl[tlic_pkg::SEC_SPI_EN];
        en[tlic_pkg::SRC_UART] = irq_enable_reg[tlic_pkg::EN_UART];
        en[tlic_pkg::SRC_T2] = irq_enable_reg[tlic_pkg::EN_T2];
        en[tlic_pkg::SRC_WK] = secondary_irq_ctrl[tlic_pkg::SEC_WK_EN];
    end

    always_comb
    begin
        hi = '0;
        hi[tlic_pkg::SRC_PSM] = secondary_irq_ctrl[tlic_pkg::SEC_PSM_PRIO];
        hi[tlic_pkg::SRC_WD] = 1'b1;
        hi[tlic_pkg::SRC_EXT0] = irq_priority_reg[tlic_pkg::EN_EXT0];
        hi[tlic_pkg::SRC_ADC] = irq_priority_reg[tlic_pkg::EN_ADC];
        hi[tlic_pkg::SRC_T0] = irq_priority_reg[tlic_pkg::EN_T0];
        hi[tlic_pkg::SRC_EXT1] = irq_priority_reg[tlic_pkg::EN_EXT1];
        hi[tlic_pkg::SRC_T1] = irq_priority_reg[tlic_pkg::EN_T1];
        hi[tlic_pkg::SRC_SPI] = secondary_irq_ctrl[tlic_pkg::SEC_SPI_PRIO];
        hi[tlic_pkg::SRC_UART] = irq_priority_reg[tlic_pkg::EN_UART];
        hi[tlic_pkg::SRC_T2] = irq_priority_reg[tlic_pkg::EN_T2];
        hi[tlic_pkg::SRC_WK] = secondary_irq_ctrl[tlic_pkg::SEC_WK_PRIO];
    end

    always_comb
    begin
        wd_only = '0;
        wd_only[tlic_pkg::SRC_WD] = 1'b1;
        elig = req & en & (irq_enable_reg[tlic_pkg::EN_GLOBAL] ? '1 : wd_only);
        if (hi_active)
            cand = '0;
        else if (lo_active)
            cand = elig & hi;
        else
            cand = elig;
    end

    // ********************************************************
    // Arbitration
    // ********************************************************
    logic gnt_valid;
    logic [3:0] gnt_idx;
    logic gnt_hi;

    tlic_arb u_arb (
        .cand(cand),
        .hi(hi),
        .gnt_valid(gnt_valid),
        .gnt_idx(gnt_idx),
        .gnt_hi(gnt_hi)
    );

    // ********************************************************
    // Acceptance, service level and watchdog
    // ********************************************************
    logic take_d;
    logic [15:0] vector_d;
    logic [3:0] src_d;
    logic wd_set;
    logic wd_clr;
    logic wd_reset_d;

    // One cycle gap after a take so the core can jump first
    always_comb
    begin
        take_d = insn_boundary & gnt_valid & ~irq_take;
        vector_d = take_d ? tlic_pkg::vector_of(gnt_idx) : irq_vector;
        src_d = take_d ? gnt_idx : irq_src;
    end

    always_comb
    begin
        wd_set = wd_timeout & wdc[tlic_pkg::WDC_SEL]
            & (wdc[tlic_pkg::WDC_TMO_MSB:tlic_pkg::WDC_TMO_LSB] != 4'h0);
        wd_clr = take_d && gnt_idx == tlic_pkg::SRC_WD;
        // A new timeout in the clearing cycle is kept
        wd_flag_d = (wd_flag_q & ~wd_clr) | wd_set;
        wd_reset_d = wd_timeout & ~wdc[tlic_pkg::WDC_SEL];
    end

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            tlic_pkg::ST_IDLE:
                if (take_d)
                    state_d = gnt_hi ? tlic_pkg::ST_HI : tlic_pkg::ST_LO;
            tlic_pkg::ST_LO:
                if (take_d)
                    state_d = tlic_pkg::ST_HI_LO;
                else if (reti_done)
                    state_d = tlic_pkg::ST_IDLE;
            tlic_pkg::ST_HI:
                if (reti_done)
                    state_d = tlic_pkg::ST_IDLE;
            tlic_pkg::ST_HI_LO:
                if (reti_done)
                    state_d = tlic_pkg::ST_LO;
            default:
                state_d = tlic_pkg::ST_IDLE;
        endcase
    end

    // take pulse tells core to push PC and jump
    always_ff @(posedge core_clk or negedge rst_s_n)
    begin
        if (!rst_s_n)
        begin
            state_q <= tlic_pkg::ST_IDLE;
            wd_flag_q <= 1'b0;
            irq_take <= 1'b0;
            irq_vector <= 16'h0000;
            irq_src <= 4'h0;
            wd_reset_req <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            wd_flag_q <= wd_flag_d;
            irq_take <= take_d;
            irq_vector <= vector_d;
            irq_src <= src_d;
            wd_reset_req <= wd_reset_d;
        end
    end

    // ********************************************************
    // Checks
    // ********************************************************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_s_n);

    global_gate_a: assert property (
        irq_take && irq_src != tlic_pkg::SRC_WD |-> $past(irq_enable_reg[tlic_pkg::EN_GLOBAL]))
        else $error("maskable source taken with global enable off");
    vector_map_a: assert property (
        irq_take |-> irq_vector == tlic_pkg::vector_of(irq_src))
        else $error("vector does not match source");
    same_level_a: assert property (
        $past(hi_active) |-> !irq_take)
        else $error("take while high routine runs");
    preempt_only_hi_a: assert property (
        lo_active && take_d |=> state_q == tlic_pkg::ST_HI_LO)
        else $error("low routine preempted by non-high take");
    high_first_a: assert property (
        take_d && |(cand & hi) |-> gnt_hi && hi[gnt_idx])
        else $error("low granted while high pending");
    poll_order_a: assert property (
        take_d |-> (cand & (gnt_hi ? hi : ~hi) & ((11'h001 << gnt_idx) - 11'h001)) == '0)
        else $error("lower poll index skipped");
    // A high supply monitor request is polled ahead of the watchdog
    wd_bypass_a: assert property (
        wd_flag_q && !hi_active && insn_boundary && !irq_take
        && !(cand[tlic_pkg::SRC_PSM] && hi[tlic_pkg::SRC_PSM])
        |=> irq_take && irq_src == tlic_pkg::SRC_WD)
        else $error("watchdog not taken");
    wd_zero_a: assert property (
        wd_timeout && !wd_flag_q
        && wdc[tlic_pkg::WDC_TMO_MSB:tlic_pkg::WDC_TMO_LSB] == 4'h0 |=> !wd_flag_q)
        else $error("watchdog flag set with zero timeout");
    wd_reset_a: assert property (
        wd_timeout |=> wd_reset_req == !$past(wdc[tlic_pkg::WDC_SEL]))
        else $error("watchdog reset request wrong");
    return_level_a: assert property (
        state_q == tlic_pkg::ST_HI_LO && reti_done |=> state_q == tlic_pkg::ST_LO ##0 !irq_take)
        else $error("return did not restore low level");

endmodule

// ### tb/tlic_core_model.sv
// Behavioural processor core that takes interrupts and returns from them
`timescale 1ns/1ns
module tlic_core_model (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic irq_take,
    input wire logic [15:0] irq_vector,
    input wire logic reti_req,
    output logic insn_boundary,
    output logic reti_done,
    output logic [15:0] pc_q
);
    logic [15:0] stack_q [0:7];
    logic [2:0] sp_q;

    // Boundary every other cycle, so takes are never instant
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            insn_boundary <= 1'b0;
            reti_done <= 1'b0;
            pc_q <= 16'h1234;
            sp_q <= 3'h0;
        end
        else
        begin
            insn_boundary <= !insn_boundary;
            reti_done <= reti_req;
            if (irq_take)
            begin
                stack_q[sp_q] <= pc_q;
                sp_q <= sp_q + 3'h1;
                pc_q <= irq_vector;
            end
            else if (reti_req)
            begin
                pc_q <= stack_q[sp_q - 3'h1];
                sp_q <= sp_q - 3'h1;
            end
        end
    end
endmodule

// ### tb/two_level_interrupt_controller_test.sv
// Self-checking bench of the interrupt controller
`timescale 1ns/1ns
module two_level_interrupt_controller_test;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic bwr = 1'b0;
    logic [7:0] baddr = 8'h00;
    logic bdat = 1'b0;
    logic [12:0] fl = 13'h0000;
    logic wdt = 1'b0;
    logic ib;
    logic rdone;
    logic rq = 1'b0;
    logic irq_take;
    logic [15:0] irq_vector;
    logic [3:0] irq_src;
    logic wd_reset_req;
    logic [15:0] pc_q;
    int miscompares = 0;
    int checks_done = 0;
    int cyc = 0;
    logic [15:0] vec [0:10] = '{16'h0043, 16'h005B, 16'h0003, 16'h0033, 16'h000B,
        16'h0013, 16'h001B, 16'h003B, 16'h0023, 16'h002B, 16'h0053};
    logic [12:0] msk [0:10] = '{13'h0001, 13'h0000, 13'h0002, 13'h000C, 13'h0010,
        13'h0020, 13'h0040, 13'h0080, 13'h0300, 13'h0C00, 13'h1000};

    tlic_top dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(addr), .reg_wdata(wdata),
        .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .bit_wr(bwr), .bit_addr(baddr),
        .bit_wdata(bdat), .supply_monitor_irq_flag(fl[0]), .ext0_irq_flag(fl[1]),
        .primary_adc_done(fl[2]), .aux_adc_done(fl[3]), .timer0_overflow_flag(fl[4]),
        .ext1_irq_flag(fl[5]), .timer1_overflow_flag(fl[6]), .spi_irq_flag(fl[7]),
        .uart_rx_flag(fl[8]), .uart_tx_flag(fl[9]), .timer2_overflow_flag(fl[10]),
        .timer2_external_flag(fl[11]), .wakeup_counter_irq_flag(fl[12]),
        .wd_timeout(wdt), .insn_boundary(ib), .reti_done(rdone), .irq_take(irq_take),
        .irq_vector(irq_vector), .irq_src(irq_src), .wd_reset_req(wd_reset_req));

    tlic_core_model core (.core_clk(core_clk), .rst_n(rst_n), .irq_take(irq_take),
        .irq_vector(irq_vector), .reti_req(rq), .insn_boundary(ib), .reti_done(rdone),
        .pc_q(pc_q));

    // ****************************************
    // Clock, hang guard and verdict
    // ****************************************
    initial
    begin
        forever #5 core_clk = !core_clk;
    end

    // Hang guard, run needs under a thousand cycles
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            miscompares++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ****************************************
    // Access and compare tasks
    // ****************************************
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks_done++;
        if (g !== e)
        begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        #1;
        chk(rdata, e);
    endtask

    task automatic no_take(input int n);
        repeat (n)
        begin
            @(posedge core_clk);
            #1;
            chk(irq_take, 1'b0);
        end
    endtask

    // Bounded wait for a take, then vector, source and core jump
    task automatic wait_take(input logic [3:0] s, input logic [15:0] v);
        int n;
        n = 0;
        @(posedge core_clk);
        #1;
        while (irq_take !== 1'b1 && n < 20)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk(irq_take, 1'b1);
        chk(irq_src, s);
        chk(irq_vector, v);
        @(posedge core_clk);
        #1;
        chk(pc_q, v);
    endtask

    // Routine clears its flags and returns
    task automatic do_reti(input logic [12:0] m);
        @(posedge core_clk);
        rq <= 1'b1;
        fl <= fl & ~m;
        @(posedge core_clk);
        rq <= 1'b0;
    endtask

    task automatic wd_pulse(input logic e);
        @(posedge core_clk);
        wdt <= 1'b1;
        @(posedge core_clk);
        wdt <= 1'b0;
        #1;
        chk(wd_reset_req, e);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        rd_chk(tlic_pkg::ADDR_ENABLE, 8'h00);
        rd_chk(tlic_pkg::ADDR_SECONDARY, 8'hA0);
        rd_chk(tlic_pkg::ADDR_PRIORITY, 8'h00);
        wr_reg(tlic_pkg::ADDR_PRIORITY, 8'hFF);
        rd_chk(tlic_pkg::ADDR_PRIORITY, 8'h7F);
        wr_reg(tlic_pkg::ADDR_PRIORITY, 8'h00);
        rd_chk(8'h55, 8'h00);
        // Global enable off holds back an enabled source
        wr_reg(tlic_pkg::ADDR_ENABLE, 8'h01);
        @(posedge core_clk);
        fl <= 13'h0002;
        no_take(6);
        @(posedge core_clk);
        bwr <= 1'b1;
        baddr <= 8'hAF;
        bdat <= 1'b1;
        @(posedge core_clk);
        bwr <= 1'b0;
        wait_take(4'h2, 16'h0003);
        rd_chk(tlic_pkg::ADDR_ENABLE, 8'h81);
        do_reti(13'h0002);
        no_take(4);
        // All sources but the watchdog at once, served one by one in polling order
        wr_reg(tlic_pkg::ADDR_ENABLE, 8'hFF);
        wr_reg(tlic_pkg::ADDR_SECONDARY, 8'h07);
        @(posedge core_clk);
        fl <= 13'h1FFF;
        for (int s = 0; s < 11; s++)
        begin
            if (s != 1)
            begin
                wait_take(s[3:0], vec[s]);
                no_take(4);
                do_reti(msk[s]);
            end
        end
        no_take(4);
        // Mixed levels, then preemption of a low routine
        wr_reg(tlic_pkg::ADDR_ENABLE, 8'hA1);
        wr_reg(tlic_pkg::ADDR_PRIORITY, 8'h20);
        @(posedge core_clk);
        fl <= 13'h0402;
        wait_take(4'h9, 16'h002B);
        no_take(4);
        do_reti(13'h0C00);
        wait_take(4'h2, 16'h0003);
        wr_reg(tlic_pkg::ADDR_SECONDARY, 8'h11);
        @(posedge core_clk);
        fl <= fl | 13'h0080;
        wait_take(4'h7, 16'h003B);
        // Status: both levels active, last source SPI
        rd_chk(tlic_pkg::ADDR_STAT, 8'h37);
        do_reti(13'h0080);
        wr_reg(tlic_pkg::ADDR_WDC, 8'hF1);
        rd_chk(tlic_pkg::ADDR_WDC, 8'hF1);
        wd_pulse(1'b0);
        wait_take(4'h1, 16'h005B);
        do_reti(13'h0000);
        do_reti(13'h0002);
        no_take(4);
        chk(pc_q, 16'h1234);
        // Watchdog with global enable off
        wr_reg(tlic_pkg::ADDR_ENABLE, 8'h00);
        wr_reg(tlic_pkg::ADDR_WDC, 8'h01);
        wd_pulse(1'b0);
        no_take(6);
        wr_reg(tlic_pkg::ADDR_WDC, 8'h00);
        wd_pulse(1'b1);
        wr_reg(tlic_pkg::ADDR_WDC, 8'hF1);
        wd_pulse(1'b0);
        wait_take(4'h1, 16'h005B);
        do_reti(13'h0000);
        no_take(4);
        give_verdict();
    end
endmodule
